/* logic/dcrv_pkg.sv */
// Purpose: constants for the playback route, mute and volume block
// Assumes: 8-bit control registers behind a byte-wide register port
// Notes:   gain codes are signed, 0.5 dB per count
package dcrv_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] DCRV_OFS_SETUP = 8'h3f;
	localparam logic [7:0] DCRV_OFS_MUTE  = 8'h40;
	localparam logic [7:0] DCRV_OFS_LGAIN = 8'h41;
	localparam logic [7:0] DCRV_OFS_RGAIN = 8'h42;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] DCRV_RST_SETUP = 8'h14;
	localparam logic [7:0] DCRV_RST_MUTE  = 8'h0c;
	localparam logic [7:0] DCRV_RST_GAIN  = 8'h00;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int DCRV_BIT_LPWR  = 7;
	localparam int DCRV_BIT_RPWR  = 6;
	localparam int DCRV_LSRC_HI   = 5;
	localparam int DCRV_LSRC_LO   = 4;
	localparam int DCRV_RSRC_HI   = 3;
	localparam int DCRV_RSRC_LO   = 2;
	localparam int DCRV_STEP_HI   = 1;
	localparam int DCRV_STEP_LO   = 0;
	localparam int DCRV_BIT_LMUTE = 3;
	localparam int DCRV_BIT_RMUTE = 2;
	localparam int DCRV_GANG_HI   = 1;
	localparam int DCRV_GANG_LO   = 0;

	// ------------------------------------------------------------
	// field codes
	// ------------------------------------------------------------
	localparam logic [1:0] DCRV_SRC_OFF   = 2'h0;
	localparam logic [1:0] DCRV_SRC_OWN   = 2'h1;
	localparam logic [1:0] DCRV_SRC_SWAP  = 2'h2;
	localparam logic [1:0] DCRV_SRC_MEAN  = 2'h3;
	localparam logic [1:0] DCRV_STEP_1    = 2'h0;
	localparam logic [1:0] DCRV_STEP_2    = 2'h1;
	localparam logic [1:0] DCRV_STEP_NONE = 2'h2;
	localparam logic [1:0] DCRV_GANG_R2L  = 2'h1;
	localparam logic [1:0] DCRV_GANG_L2R  = 2'h2;
endpackage : dcrv_pkg

/* logic/dcrv_top.sv */
// Purpose: playback channel power, source routing, mute and soft-stepped digital volume
// Assumes: sample_valid_in pulses once per sample period; register port is already decoded
// Notes:   data out is routed and muted; the applied gain code travels beside it to the scaler
`timescale 1ns/1ps

// Functional notes
// - left channel powered only while its power bit is one; reset off
// - right channel powered only while its power bit is one; reset off
// - left source: 00 silence, 01 left, 10 right, 11 mean; reset 01
// - right source: 00 silence, 01 right, 10 left, 11 mean; reset 01
// - soft-step: 00 one step per sample, 01 per two, 10 immediate
// - left output silent while left mute bit is one; reset muted
// - right output silent while right mute bit is one; reset muted
// - gang 01: left uses right gain register
// - gang 10: right uses left gain register
// - gang 00 or 11: independent gains; reset 00
// - compressor active forces independent gains; gang code is ignored while it runs
// - gain is signed 8-bit in 0.5 dB units, +24 to -63.5 dB; codes are not clamped, so +63.5 to -64 dB pass through
// - both gain registers reset to zero, separate registers
module dcrv_top #(
	parameter int SW = 24
) (
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_n_in,
	// register port
	input  wire logic                  reg_wr_in,
	input  wire logic                  reg_rd_in,
	input  wire logic [7:0]            reg_addr_in,
	input  wire logic [7:0]            reg_wdata_in,
	output logic      [7:0]            reg_rdata_out,
	// compressor status
	input  wire logic                  compressor_left_in,
	input  wire logic                  compressor_right_in,
	// sample input
	input  wire logic                  sample_valid_in,
	input  wire logic signed [SW-1:0]  left_sample_in,
	input  wire logic signed [SW-1:0]  right_sample_in,
	// channel outputs
	output logic                       left_power_out,
	output logic                       right_power_out,
	output logic                       out_valid_out,
	output logic signed [SW-1:0]       left_data_out,
	output logic signed [SW-1:0]       right_data_out,
	output logic signed [7:0]          left_gain_out,
	output logic signed [7:0]          right_gain_out
);
	import dcrv_pkg::*;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_q1;
	logic rst_sync_n;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_q1     <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_q1     <= 1'b1;
			rst_sync_n <= rst_q1;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] setup;
	logic [7:0] mute_gang;
	logic [7:0] lgain;
	logic [7:0] rgain;
	logic [7:0] next_setup;
	logic [7:0] next_mute_gang;
	logic [7:0] next_lgain;
	logic [7:0] next_rgain;
	logic [7:0] next_rdata;

	always_comb begin
		next_setup     = setup;
		next_mute_gang = mute_gang;
		next_lgain     = lgain;
		next_rgain     = rgain;
		next_rdata     = reg_rdata_out;
		if (reg_wr_in) begin
			case (reg_addr_in)
				DCRV_OFS_SETUP: next_setup     = reg_wdata_in;
				DCRV_OFS_MUTE:  next_mute_gang = reg_wdata_in;
				DCRV_OFS_LGAIN: next_lgain     = reg_wdata_in;
				DCRV_OFS_RGAIN: next_rgain     = reg_wdata_in;
				default:        next_setup     = setup;
			endcase
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				DCRV_OFS_SETUP: next_rdata = setup;
				DCRV_OFS_MUTE:  next_rdata = mute_gang;
				DCRV_OFS_LGAIN: next_rdata = lgain;
				DCRV_OFS_RGAIN: next_rdata = rgain;
				default:        next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			setup         <= DCRV_RST_SETUP;
			mute_gang     <= DCRV_RST_MUTE;
			lgain         <= DCRV_RST_GAIN;
			rgain         <= DCRV_RST_GAIN;
			reg_rdata_out <= 8'h00;
		end else begin
			setup         <= next_setup;
			mute_gang     <= next_mute_gang;
			lgain         <= next_lgain;
			rgain         <= next_rgain;
			reg_rdata_out <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// field decode
	// ------------------------------------------------------------
	logic [1:0] lsrc;
	logic [1:0] rsrc;
	logic [1:0] step_mode;
	logic [1:0] gang;
	logic       compressor_any;

	assign lsrc      = setup[DCRV_LSRC_HI:DCRV_LSRC_LO];
	assign rsrc      = setup[DCRV_RSRC_HI:DCRV_RSRC_LO];
	assign step_mode = setup[DCRV_STEP_HI:DCRV_STEP_LO];
	assign gang      = mute_gang[DCRV_GANG_HI:DCRV_GANG_LO];
	assign compressor_any = compressor_left_in | compressor_right_in;

	// ------------------------------------------------------------
	// gain targets and soft stepping
	// ------------------------------------------------------------
	logic signed [7:0] ltarget;
	logic signed [7:0] rtarget;
	logic              step_phase;
	logic              step_tick;
	logic              next_step_phase;
	logic signed [7:0] next_lapplied;
	logic signed [7:0] next_rapplied;

	// the compressor needs each channel's own gain, so ganging is dropped while it runs
	always_comb begin
		ltarget = lgain;
		rtarget = rgain;
		if (!compressor_any && gang == DCRV_GANG_R2L) begin
			ltarget = rgain;
		end
		if (!compressor_any && gang == DCRV_GANG_L2R) begin
			rtarget = lgain;
		end
	end

	// reserved step code 11 falls back to one step per sample
	always_comb begin
		next_step_phase = step_phase;
		if (sample_valid_in) begin
			next_step_phase = ~step_phase;
		end
		step_tick = sample_valid_in && (step_mode != DCRV_STEP_2 || step_phase);
	end

	function automatic logic signed [7:0] dcrv_step(input logic signed [7:0] cur,
		input logic signed [7:0] tgt, input logic tick, input logic [1:0] mode);
		logic signed [7:0] res;
		res = cur;
		if (mode == DCRV_STEP_NONE) begin
			res = tgt;
		end else if (tick && cur < tgt) begin
			res = cur + 8'sh01;
		end else if (tick && cur > tgt) begin
			res = cur - 8'sh01;
		end
		return res;
	endfunction : dcrv_step

	always_comb begin
		next_lapplied = dcrv_step(left_gain_out, ltarget, step_tick, step_mode);
		next_rapplied = dcrv_step(right_gain_out, rtarget, step_tick, step_mode);
	end

	always_ff @(posedge clk_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			step_phase     <= 1'b0;
			left_gain_out  <= 8'sh00;
			right_gain_out <= 8'sh00;
		end else begin
			step_phase     <= next_step_phase;
			left_gain_out  <= next_lapplied;
			right_gain_out <= next_rapplied;
		end
	end

	// ------------------------------------------------------------
	// routing, mute and power
	// ------------------------------------------------------------
	logic signed [SW:0]   sum_ext;
	logic signed [SW-1:0] mean;
	logic signed [SW-1:0] next_ldata;
	logic signed [SW-1:0] next_rdata_s;
	logic                 next_valid;

	function automatic logic signed [SW-1:0] dcrv_pick(input logic [1:0] src,
		input logic signed [SW-1:0] own, input logic signed [SW-1:0] other,
		input logic signed [SW-1:0] avg);
		logic signed [SW-1:0] res;
		case (src)
			DCRV_SRC_OWN:  res = own;
			DCRV_SRC_SWAP: res = other;
			DCRV_SRC_MEAN: res = avg;
			default:       res = '0;
		endcase
		return res;
	endfunction : dcrv_pick

	always_comb begin
		// one guard bit keeps the sum from wrapping before the halving
		sum_ext      = {left_sample_in[SW-1], left_sample_in} + {right_sample_in[SW-1], right_sample_in};
		mean         = SW'(sum_ext >>> 1);
		next_ldata   = left_data_out;
		next_rdata_s = right_data_out;
		next_valid   = sample_valid_in;
		if (sample_valid_in) begin
			next_ldata   = dcrv_pick(lsrc, left_sample_in, right_sample_in, mean);
			next_rdata_s = dcrv_pick(rsrc, right_sample_in, left_sample_in, mean);
			if (mute_gang[DCRV_BIT_LMUTE] || !setup[DCRV_BIT_LPWR]) begin
				next_ldata = '0;
			end
			if (mute_gang[DCRV_BIT_RMUTE] || !setup[DCRV_BIT_RPWR]) begin
				next_rdata_s = '0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			left_power_out  <= 1'b0;
			right_power_out <= 1'b0;
			out_valid_out   <= 1'b0;
			left_data_out   <= '0;
			right_data_out  <= '0;
		end else begin
			left_power_out  <= setup[DCRV_BIT_LPWR];
			right_power_out <= setup[DCRV_BIT_RPWR];
			out_valid_out   <= next_valid;
			left_data_out   <= next_ldata;
			right_data_out  <= next_rdata_s;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking dcrv_cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_sync_n);

	sequence s_step_pending;
		step_tick && step_mode != DCRV_STEP_NONE && left_gain_out != ltarget;
	endsequence

	power_left_a: assert property (setup[DCRV_BIT_LPWR] ##1 setup[DCRV_BIT_LPWR] |-> left_power_out)
		else $error("left power not following its bit");
	power_right_a: assert property (!setup[DCRV_BIT_RPWR] |=> !right_power_out)
		else $error("right power on while its bit is clear");
	route_left_a: assert property (sample_valid_in && lsrc == DCRV_SRC_SWAP && setup[DCRV_BIT_LPWR]
		&& !mute_gang[DCRV_BIT_LMUTE] |=> left_data_out == $past(right_sample_in))
		else $error("left swap route wrong");
	route_right_a: assert property (sample_valid_in && rsrc == DCRV_SRC_MEAN && setup[DCRV_BIT_RPWR]
		&& !mute_gang[DCRV_BIT_RMUTE] |=> right_data_out == $past(mean) && out_valid_out)
		else $error("right mean route wrong");
	mute_left_a: assert property (sample_valid_in && mute_gang[DCRV_BIT_LMUTE] |=> left_data_out == '0)
		else $error("left not silent while muted");
	mute_right_a: assert property (sample_valid_in && mute_gang[DCRV_BIT_RMUTE] |=> right_data_out == '0)
		else $error("right not silent while muted");
	gang_left_a: assert property (step_mode == DCRV_STEP_NONE && gang == DCRV_GANG_R2L && !compressor_any
		|=> left_gain_out == $past(rgain))
		else $error("left gain not ganged to right");
	gang_compressor_a: assert property (step_mode == DCRV_STEP_NONE && compressor_any
		|=> right_gain_out == $past(rgain))
		else $error("gang applied while compressor active");
	step_move_a: assert property (s_step_pending |=> left_gain_out - $past(left_gain_out) == 8'sh01
		|| $past(left_gain_out) - left_gain_out == 8'sh01)
		else $error("soft step not one count");
	step_half_a: assert property (step_mode == DCRV_STEP_2 && step_tick ##1 step_mode == DCRV_STEP_2
		|-> !step_tick)
		else $error("two-sample step ticked twice in a row");
endmodule : dcrv_top

/* testbench/dcrv_host_model.sv */
// Purpose: host side stand-in that streams stereo samples into the block
// Assumes: one sample period every third clock
// Notes:   data lines change every cycle, so a stale value never looks valid
`timescale 1ns/1ps
module dcrv_host_model #(
	parameter int SW = 24
) (
	// clock
	input  wire logic             clk_in,
	// sample stream
	output logic                  valid_out,
	output logic signed [SW-1:0]  left_out,
	output logic signed [SW-1:0]  right_out
);
	localparam logic signed [SW-1:0] MAXV = {1'b0, {(SW-1){1'b1}}};
	int seed  = 32'h0658;
	int phase = 0;
	initial begin
		valid_out = 1'b0;
		left_out  = '0;
		right_out = '0;
	end
	always @(posedge clk_in) begin
		#1 phase = (phase + 1) % 24;
		valid_out = (phase % 3 == 0);
		// full-scale pair now and then, the worst case for the mean
		left_out = (phase == 0) ? MAXV : SW'($random(seed));
		right_out = (phase == 0) ? MAXV : SW'($random(seed));
	end
endmodule : dcrv_host_model

/* testbench/tb_top.sv */
// Purpose: self-checking bench for routing, mute and volume
// Assumes: host model streams samples; registers reached by the byte port
// Notes:   gains are checked as codes, scaling sits downstream
`timescale 1ns/1ps
module tb_top;
	import dcrv_pkg::*;
	localparam int SW = 24;
	logic                 clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic        [7:0]    reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
	logic                 compressor_left_in = 1'b0, compressor_right_in = 1'b0;
	logic                 sample_valid_in, left_power_out, right_power_out, out_valid_out;
	logic signed [SW-1:0] left_sample_in, right_sample_in, left_data_out, right_data_out, cap_l, cap_r;
	logic signed [7:0]    left_gain_out, right_gain_out;
	int                   errors = 0, comparisons = 0, cycles = 0;
	always #4 clk_in = ~clk_in;
	dcrv_host_model #(.SW(SW)) host (.clk_in(clk_in), .valid_out(sample_valid_in),
		.left_out(left_sample_in), .right_out(right_sample_in));
	dcrv_top #(.SW(SW)) uut (.clk_in, .rst_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
		.reg_rdata_out, .compressor_left_in, .compressor_right_in, .sample_valid_in, .left_sample_in,
		.right_sample_in, .left_power_out, .right_power_out, .out_valid_out, .left_data_out,
		.right_data_out, .left_gain_out, .right_gain_out);
	// ------------------------------------------------------------
	// checking helpers
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic chkd(input logic [SW-1:0] got, input logic [SW-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkd
	function automatic logic signed [SW-1:0] ex(input logic [1:0] s, input logic signed [SW-1:0] o,
		input logic signed [SW-1:0] t, input logic on);
		logic signed [SW:0] sum;
		sum = {o[SW-1], o} + {t[SW-1], t};
		if (!on || s == 2'h0) return '0;
		return (s == 2'h1) ? o : (s == 2'h2) ? t : sum[SW:1];
	endfunction : ex
	// one idle edge first, so strobes never rise in the step they fell
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1 reg_wr_in = 1'b1;
		reg_addr_in = a;
		reg_wdata_in = d;
		@(posedge clk_in);
		#1 reg_wr_in = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		#1 reg_rd_in = 1'b1;
		reg_addr_in = a;
		@(posedge clk_in);
		#1 reg_rd_in = 1'b0;
		chk8(reg_rdata_out, exp);
	endtask : rd
	task automatic pulses(input int n);
		for (int k = 0; k < n; k++) @(posedge clk_in iff sample_valid_in);
		#1;
	endtask : pulses
	task automatic settle();
		@(posedge clk_in);
		#1;
	endtask : settle
	task automatic route(input logic [7:0] setup, input logic [7:0] mute);
		wr(DCRV_OFS_SETUP, setup);
		wr(DCRV_OFS_MUTE, mute);
		@(posedge clk_in);
		@(posedge clk_in iff sample_valid_in);
		cap_l = left_sample_in;
		cap_r = right_sample_in;
		// the valid pulse stands only in the cycle after the taking edge
		#1;
		chk8({7'h00, out_valid_out}, 8'h01);
		chkd(left_data_out, ex(setup[5:4], cap_l, cap_r, setup[7] & ~mute[3]));
		chkd(right_data_out, ex(setup[3:2], cap_r, cap_l, setup[6] & ~mute[2]));
		chk8({6'h00, left_power_out, right_power_out}, {6'h00, setup[7:6]});
	endtask : route
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			end_of_test();
		end
	end
	initial begin
		repeat (20) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		repeat (3) @(posedge clk_in);
		#1;
		chk8({6'h00, left_power_out, right_power_out}, 8'h00);
		rd(DCRV_OFS_SETUP, 8'h14);
		rd(DCRV_OFS_MUTE, 8'h0c);
		rd(DCRV_OFS_LGAIN, 8'h00);
		rd(DCRV_OFS_RGAIN, 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 16; i++) route({2'h3, i[3:0], 2'h2}, 8'h00);
		for (int j = 0; j < 4; j++) route({j[1:0], 4'h5, 2'h2}, {4'h0, j[1:0], 2'h0});
		$display("test routing and mute done");
		wr(DCRV_OFS_SETUP, 8'h14);
		wr(DCRV_OFS_LGAIN, 8'h04);
		pulses(2);
		chk8(left_gain_out, 8'h02);
		pulses(4);
		chk8(left_gain_out, 8'h04);
		wr(DCRV_OFS_SETUP, 8'h15);
		wr(DCRV_OFS_LGAIN, 8'h08);
		pulses(4);
		chk8(left_gain_out, 8'h06);
		wr(DCRV_OFS_SETUP, 8'h16);
		wr(DCRV_OFS_LGAIN, 8'h81);
		wr(DCRV_OFS_RGAIN, 8'h30);
		settle();
		chk8(left_gain_out, 8'h81);
		chk8(right_gain_out, 8'h30);
		$display("test soft stepping done");
		for (int g = 0; g < 4; g++) begin
			wr(DCRV_OFS_MUTE, {6'h00, g[1:0]});
			settle();
			chk8(left_gain_out, (g == 1) ? 8'h30 : 8'h81);
			chk8(right_gain_out, (g == 2) ? 8'h81 : 8'h30);
		end
		compressor_left_in = 1'b1;
		wr(DCRV_OFS_MUTE, 8'h01);
		settle();
		chk8(left_gain_out, 8'h81);
		compressor_left_in = 1'b0;
		compressor_right_in = 1'b1;
		wr(DCRV_OFS_MUTE, 8'h02);
		settle();
		chk8(right_gain_out, 8'h30);
		rd(DCRV_OFS_LGAIN, 8'h81);
		rd(DCRV_OFS_RGAIN, 8'h30);
		rd(8'h43, 8'h00);
		$display("test ganging done");
		end_of_test();
	end
endmodule : tb_top
